// [rtl/bplm_consts.svh]
// constants for the buck phase and load meter control block
// assumes a 125 MHz clk and an Avalon-MM slave with 32-bit words
`ifndef BPLM_CONSTS_SVH
`define BPLM_CONSTS_SVH

// register byte addresses
`define BPLM_ADDR_PRI_CTRL1   8'h00
`define BPLM_ADDR_PRI_CTRL2   8'h04
`define BPLM_ADDR_PRI_VOUT    8'h08
`define BPLM_ADDR_PRI_DELAY   8'h0C
`define BPLM_ADDR_SEC_CTRL1   8'h10
`define BPLM_ADDR_SEC_CTRL2   8'h14
`define BPLM_ADDR_SEC_VOUT    8'h18
`define BPLM_ADDR_SEC_DELAY   8'h1C
`define BPLM_ADDR_CONFIG      8'h20
`define BPLM_ADDR_PLL         8'h24
`define BPLM_ADDR_EVENT       8'h28
`define BPLM_ADDR_MASK        8'h2C
`define BPLM_ADDR_SEL         8'h30
`define BPLM_ADDR_RES_LO      8'h34
`define BPLM_ADDR_RES_HI      8'h38
`define BPLM_ADDR_STATUS      8'h3C

// ctrl1 fields
`define BPLM_C1_EN            0
`define BPLM_C1_FPWM          1
`define BPLM_C1_TWO_PHASE     2
`define BPLM_C1_DISCHARGE     3
// ctrl2 fields: current limit [2:0], slew [6:4]
`define BPLM_C2_ILIM_LSB      0
`define BPLM_C2_SLEW_LSB      4
// config / pll / select / event fields
`define BPLM_CFG_SPREAD       0
`define BPLM_PLL_EXT_SYNC     0
`define BPLM_SEL_BIT          0
`define BPLM_EV_DONE          0
`define BPLM_EV_SEC_LIMIT     1
`define BPLM_EV_PRI_LIMIT     2

// measurement timing
`define BPLM_MEAS_MAX_US      50
`define BPLM_CLK_MHZ          125
`define BPLM_MEAS_CYCLES      (`BPLM_MEAS_MAX_US * `BPLM_CLK_MHZ)
// code step, pwm threshold and phase add/shed thresholds in mA
`define BPLM_STEP_MA          20
`define BPLM_PWM_MA           600
`define BPLM_ADD_PHASE_MA     2000
`define BPLM_SHED_PHASE_MA    1500

`endif

// [rtl/bplm_pkg.sv]
// types for the buck phase and load meter control block
// assumes bplm_consts.svh is included by the user
package bplm_pkg;
  typedef enum logic [1:0] {
    BPLM_IDLE,
    BPLM_SETTLE,
    BPLM_SAMPLE
  } bplm_meas_t;
endpackage

// [rtl/bplm_ctrl.sv]
// phase, mode, spread and load meter control for two buck cores
// assumes an Avalon-MM master, analog current sense as mA codes
`include "bplm_consts.svh"
module bplm_ctrl
  import bplm_pkg::*;
#(
  parameter int MEAS_CYCLES = `BPLM_MEAS_CYCLES,
  parameter logic [7:0] OTP_CTRL1 = 8'h01,
  parameter logic [7:0] OTP_CTRL2 = 8'h03,
  parameter logic [7:0] OTP_VOUT  = 8'h50,
  parameter logic [7:0] OTP_DELAY = 8'h00
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             avs_response_err,
  input  wire logic [11:0] pri_sense_ma,
  input  wire logic [11:0] sec_sense_ma,
  input  wire logic        pri_limit_hit,
  input  wire logic        sec_limit_hit,
  output logic             irq,
  output logic             pri_pwm,
  output logic             sec_pwm,
  output logic             pri_enable,
  output logic             sec_enable,
  output logic             two_phase_active,
  output logic             sec_phase_180,
  output logic             spread_on,
  output logic [7:0]       pri_vout,
  output logic [7:0]       sec_vout,
  output logic [2:0]       sec_current_limit,
  output logic             sec_discharge_enable
);

  logic [7:0]  pri_ctrl_reg_1, pri_ctrl_reg_2, pri_voltage_reg;
  logic [7:0]  pri_delay_reg;
  logic [7:0]  secondary_ctrl_reg_1, secondary_ctrl_reg_2;
  logic [7:0]  secondary_voltage_reg, secondary_delay_reg;
  logic        spread_enable, ext_sync_enable, meter_sel;
  logic        meter_done_flag, meter_done_mask;
  logic        secondary_limit_event, pri_limit_event;
  logic        sec_limit_mask, pri_limit_mask;
  logic [8:0]  meter_result;
  bplm_meas_t  meas_st;
  logic [15:0] meas_cnt;
  logic        meas_busy, meas_done, meter_on_sec;
  logic        second_phase;
  logic        wr_acc, rd_acc, hit;
  logic [31:0] next_readdata;
  logic [12:0] sum_ma;
  logic [12:0] code_full;
  logic [8:0]  next_result;
  logic        force_two_phase;
  logic [15:0] meas_age;

  assign force_two_phase = pri_ctrl_reg_1[`BPLM_C1_TWO_PHASE];
  // one-cycle answer: waitrequest low in the cycle after the request
  assign wr_acc = avs_write & ~avs_waitrequest;
  assign rd_acc = avs_read & ~avs_waitrequest;

  // address decode
  always_comb begin
    hit = 1'b1;
    next_readdata = 32'h0000_0000;
    unique case (avs_address)
      `BPLM_ADDR_PRI_CTRL1: next_readdata[7:0] = pri_ctrl_reg_1;
      `BPLM_ADDR_PRI_CTRL2: next_readdata[7:0] = pri_ctrl_reg_2;
      `BPLM_ADDR_PRI_VOUT:  next_readdata[7:0] = pri_voltage_reg;
      `BPLM_ADDR_PRI_DELAY: next_readdata[7:0] = pri_delay_reg;
      `BPLM_ADDR_SEC_CTRL1: next_readdata[7:0] = secondary_ctrl_reg_1;
      `BPLM_ADDR_SEC_CTRL2: next_readdata[7:0] = secondary_ctrl_reg_2;
      `BPLM_ADDR_SEC_VOUT:  next_readdata[7:0] = secondary_voltage_reg;
      `BPLM_ADDR_SEC_DELAY: next_readdata[7:0] = secondary_delay_reg;
      `BPLM_ADDR_CONFIG:    next_readdata[0] = spread_enable;
      `BPLM_ADDR_PLL:       next_readdata[0] = ext_sync_enable;
      `BPLM_ADDR_EVENT:     next_readdata[2:0] = {pri_limit_event,
                              secondary_limit_event, meter_done_flag};
      `BPLM_ADDR_MASK:      next_readdata[2:0] = {pri_limit_mask,
                              sec_limit_mask, meter_done_mask};
      `BPLM_ADDR_SEL:       next_readdata[0] = meter_sel;
      `BPLM_ADDR_RES_LO:    next_readdata[7:0] = meter_result[7:0];
      `BPLM_ADDR_RES_HI:    next_readdata[0] = meter_result[8];
      `BPLM_ADDR_STATUS:    next_readdata[3:0] = {spread_on, second_phase,
                              two_phase_active, meas_busy};
      default:              hit = 1'b0;
    endcase
  end

  // bus handshake and read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      avs_response_err <= 1'b0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if ((avs_read | avs_write) & avs_waitrequest) begin
        avs_readdata <= avs_read ? next_readdata : 32'h0000_0000;
        avs_response_err <= ~hit;
      end
    end
  end

  // converter setting registers, defaults from otp; spread, sync, mask and select bits reset to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pri_ctrl_reg_1 <= OTP_CTRL1;
      pri_ctrl_reg_2 <= OTP_CTRL2;
      pri_voltage_reg <= OTP_VOUT;
      pri_delay_reg <= OTP_DELAY;
      secondary_ctrl_reg_1 <= OTP_CTRL1;
      secondary_ctrl_reg_2 <= OTP_CTRL2;
      secondary_voltage_reg <= OTP_VOUT;
      secondary_delay_reg <= OTP_DELAY;
      spread_enable <= 1'b0;
      ext_sync_enable <= 1'b0;
      meter_done_mask <= 1'b0;
      sec_limit_mask <= 1'b0;
      pri_limit_mask <= 1'b0;
      meter_sel <= 1'b0;
    end else if (wr_acc && avs_byteenable[0]) begin
      unique case (avs_address)
        `BPLM_ADDR_PRI_CTRL1: pri_ctrl_reg_1 <= avs_writedata[7:0];
        `BPLM_ADDR_PRI_CTRL2: pri_ctrl_reg_2 <= avs_writedata[7:0];
        `BPLM_ADDR_PRI_VOUT:  pri_voltage_reg <= avs_writedata[7:0];
        `BPLM_ADDR_PRI_DELAY: pri_delay_reg <= avs_writedata[7:0];
        `BPLM_ADDR_SEC_CTRL1: secondary_ctrl_reg_1 <= avs_writedata[7:0];
        `BPLM_ADDR_SEC_CTRL2: secondary_ctrl_reg_2 <= avs_writedata[7:0];
        `BPLM_ADDR_SEC_VOUT:  secondary_voltage_reg <= avs_writedata[7:0];
        `BPLM_ADDR_SEC_DELAY: secondary_delay_reg <= avs_writedata[7:0];
        `BPLM_ADDR_CONFIG:    spread_enable <= avs_writedata[0];
        `BPLM_ADDR_PLL:       ext_sync_enable <= avs_writedata[0];
        `BPLM_ADDR_MASK: begin
          meter_done_mask <= avs_writedata[0];
          sec_limit_mask <= avs_writedata[1];
          pri_limit_mask <= avs_writedata[2];
        end
        `BPLM_ADDR_SEL:       meter_sel <= avs_writedata[`BPLM_SEL_BIT];
        default: ;
      endcase
    end
  end

  // event flags: write one to clear, a new event wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meter_done_flag <= 1'b0;
      secondary_limit_event <= 1'b0;
      pri_limit_event <= 1'b0;
    end else begin
      if (meas_done)
        meter_done_flag <= 1'b1;
      else if (wr_acc && avs_address == `BPLM_ADDR_EVENT &&
               avs_byteenable[0] && avs_writedata[0])
        meter_done_flag <= 1'b0;
      // secondary limit event stays live in two-phase mode
      if (sec_limit_hit)
        secondary_limit_event <= 1'b1;
      else if (wr_acc && avs_address == `BPLM_ADDR_EVENT &&
               avs_byteenable[0] && avs_writedata[1])
        secondary_limit_event <= 1'b0;
      if (pri_limit_hit)
        pri_limit_event <= 1'b1;
      else if (wr_acc && avs_address == `BPLM_ADDR_EVENT &&
               avs_byteenable[0] && avs_writedata[2])
        pri_limit_event <= 1'b0;
    end
  end

  // interrupt output
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= (meter_done_flag & ~meter_done_mask) |
             (secondary_limit_event & ~sec_limit_mask) |
             (pri_limit_event & ~pri_limit_mask);
  end

  // sum both phases in two-phase mode, pick one otherwise
  always_comb begin
    if (force_two_phase)
      sum_ma = {1'b0, pri_sense_ma} + {1'b0, sec_sense_ma};
    else if (meter_on_sec)
      sum_ma = {1'b0, sec_sense_ma};
    else
      sum_ma = {1'b0, pri_sense_ma};
    code_full = 13'(sum_ma / 13'(`BPLM_STEP_MA));
    next_result = (code_full > 13'h01FF) ? 9'h1FF : code_full[8:0];
  end

  // measurement sequence, a select write restarts it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meas_st <= BPLM_IDLE;
      meas_cnt <= 16'h0000;
      meas_done <= 1'b0;
      meter_on_sec <= 1'b0;
      meter_result <= 9'h000;
    end else begin
      meas_done <= 1'b0;
      if (wr_acc && avs_address == `BPLM_ADDR_SEL && avs_byteenable[0]) begin
        meas_st <= BPLM_SETTLE;
        meas_cnt <= 16'h0000;
        meter_on_sec <= avs_writedata[`BPLM_SEL_BIT];
      end else begin
        unique case (meas_st)
          BPLM_IDLE: ;
          BPLM_SETTLE: begin
            meas_cnt <= meas_cnt + 16'h0001;
            if (meas_cnt == 16'(MEAS_CYCLES - 2))
              meas_st <= BPLM_SAMPLE;
          end
          BPLM_SAMPLE: begin
            meter_result <= next_result;
            meas_done <= 1'b1;
            meas_st <= BPLM_IDLE;
          end
        endcase
      end
    end
  end
  assign meas_busy = (meas_st != BPLM_IDLE);

  // cycles spent in the running measurement, read by the checks
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      meas_age <= 16'h0000;
    else if (!meas_busy ||
             (wr_acc && avs_address == `BPLM_ADDR_SEL && avs_byteenable[0]))
      meas_age <= 16'h0000;
    else
      meas_age <= meas_age + 16'h0001;
  end

  // automatic phase add and shed with hysteresis
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      second_phase <= 1'b0;
    else if (force_two_phase)
      second_phase <= 1'b1;
    else if (pri_sense_ma >= 12'(`BPLM_ADD_PHASE_MA))
      second_phase <= 1'b1;
    else if (pri_sense_ma < 12'(`BPLM_SHED_PHASE_MA))
      second_phase <= 1'b0;
  end

  // converter mode outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pri_pwm <= 1'b0;
      sec_pwm <= 1'b0;
      pri_enable <= 1'b0;
      sec_enable <= 1'b0;
      two_phase_active <= 1'b0;
      sec_phase_180 <= 1'b0;
      spread_on <= 1'b0;
      pri_vout <= 8'h00;
      sec_vout <= 8'h00;
      sec_current_limit <= 3'h0;
      sec_discharge_enable <= 1'b0;
    end else begin
      // pwm: forced, two-phase, measuring, or heavy load
      pri_pwm <= pri_ctrl_reg_1[`BPLM_C1_FPWM] | force_two_phase |
                 (meas_busy & (~meter_on_sec | force_two_phase)) |
                 (pri_sense_ma >= 12'(`BPLM_PWM_MA));
      // primary enable and vout govern the pair in two-phase mode; current limit and discharge stay secondary
      if (force_two_phase) begin
        sec_pwm <= 1'b1;
        sec_enable <= pri_ctrl_reg_1[`BPLM_C1_EN] & second_phase;
        sec_vout <= pri_voltage_reg;
      end else begin
        sec_pwm <= secondary_ctrl_reg_1[`BPLM_C1_FPWM] |
                   (meas_busy & meter_on_sec) |
                   (sec_sense_ma >= 12'(`BPLM_PWM_MA));
        sec_enable <= secondary_ctrl_reg_1[`BPLM_C1_EN];
        sec_vout <= secondary_voltage_reg;
      end
      pri_enable <= pri_ctrl_reg_1[`BPLM_C1_EN];
      pri_vout <= pri_voltage_reg;
      two_phase_active <= force_two_phase;
      sec_phase_180 <= force_two_phase & second_phase;
      sec_current_limit <= secondary_ctrl_reg_2[2:0];
      sec_discharge_enable <= secondary_ctrl_reg_1[`BPLM_C1_DISCHARGE];
      spread_on <= spread_enable & ~ext_sync_enable;
    end
  end

  // assertions
  // measurement steps: start by select write, end when busy drops
  sequence s_sel_write;
    wr_acc && avs_address == `BPLM_ADDR_SEL && avs_byteenable[0];
  endsequence

  sequence s_meas_end;
    $fell(meas_busy);
  endsequence

  property p_meas_bound;
    @(posedge clk) disable iff (rst)
      meas_busy |-> meas_age < 16'(MEAS_CYCLES);
  endproperty
  a_meas_bound: assert property (p_meas_bound)
    else $error("measurement overran its bound");

  property p_start_busy;
    @(posedge clk) disable iff (rst) s_sel_write |=> meas_busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("select write did not start a measurement");

  property p_meas_end;
    @(posedge clk) disable iff (rst) s_meas_end |-> meas_done;
  endproperty
  a_meas_end: assert property (p_meas_end)
    else $error("measurement ended without done");

  property p_done_sets_flag;
    @(posedge clk) disable iff (rst) meas_done |=> meter_done_flag;
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag)
    else $error("done flag not set");

  property p_mask_blocks;
    @(posedge clk) disable iff (rst)
      (meter_done_mask && !secondary_limit_event && !pri_limit_event)
      ##1 (meter_done_mask && !secondary_limit_event && !pri_limit_event)
      |-> !irq;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("masked done raised irq");

  property p_meas_pwm;
    @(posedge clk) disable iff (rst)
      (meas_busy && !meter_on_sec) ##1 meas_busy |-> pri_pwm;
  endproperty
  a_meas_pwm: assert property (p_meas_pwm)
    else $error("primary not in pwm while measured");

  property p_two_phase_pwm;
    @(posedge clk) disable iff (rst)
      force_two_phase ##1 force_two_phase |-> pri_pwm && sec_pwm;
  endproperty
  a_two_phase_pwm: assert property (p_two_phase_pwm)
    else $error("two-phase without pwm");

  property p_spread_sync;
    @(posedge clk) disable iff (rst)
      $past(ext_sync_enable) |-> !spread_on;
  endproperty
  a_spread_sync: assert property (p_spread_sync)
    else $error("spread active with external sync");

  property p_result_hold;
    @(posedge clk) disable iff (rst)
      !$past(meas_done) && !meas_done |-> $stable(meter_result);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without measurement");

  property p_sec_vout_follow;
    @(posedge clk) disable iff (rst)
      force_two_phase ##1 force_two_phase
      |-> sec_vout == $past(pri_voltage_reg);
  endproperty
  a_sec_vout_follow: assert property (p_sec_vout_follow)
    else $error("secondary vout not following primary");

  property p_flag_sticky;
    @(posedge clk) disable iff (rst)
      meter_done_flag && !(wr_acc && avs_address == `BPLM_ADDR_EVENT)
      |=> meter_done_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("done flag dropped without clear");

  property p_phase_add;
    @(posedge clk) disable iff (rst)
      !force_two_phase && pri_sense_ma >= 12'(`BPLM_ADD_PHASE_MA)
      |=> second_phase;
  endproperty
  a_phase_add: assert property (p_phase_add)
    else $error("second phase not added at heavy load");

endmodule

// [sim/bplm_load_model.sv]
// behavioural load and power stage feeding the current sense inputs
// assumes the bench sets load demand in mA, same clock as the block
module bplm_load_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [11:0] pri_demand_ma,
  input  wire logic [11:0] sec_demand_ma,
  input  wire logic        sec_fault,
  output logic [11:0]      pri_sense_ma,
  output logic [11:0]      sec_sense_ma,
  output logic             sec_limit_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fault_q;

  // sense lags demand by one clock, like a filtered sense amplifier
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pri_sense_ma <= 12'h000;
      sec_sense_ma <= 12'h000;
    end else begin
      pri_sense_ma <= pri_demand_ma;
      sec_sense_ma <= sec_demand_ma;
    end
  end

  // one limit pulse for each rising fault request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_q       <= 1'b0;
      sec_limit_hit <= 1'b0;
    end else begin
      fault_q       <= sec_fault;
      sec_limit_hit <= sec_fault & ~fault_q;
    end
  end
endmodule

// [sim/tb_buck_phase_and_load_meter_ctrl.sv]
// self-checking bench: Avalon-MM host tasks driving the control block
// assumes MEAS_CYCLES shortened to 20 and the load model for sense
`include "bplm_consts.svh"
module tb_buck_phase_and_load_meter_ctrl;
  import bplm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MC = 20;
  logic        clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address, pri_vout, sec_vout;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [3:0]  avs_byteenable;
  logic [11:0] pri_sense_ma, sec_sense_ma, pri_dem, sec_dem;
  logic        avs_response_err, sec_limit_hit, irq, pri_pwm, sec_pwm;
  logic        pri_enable, sec_enable, two_phase_active, sec_phase_180;
  logic        spread_on, sec_discharge_enable, sec_fault, e;
  logic [2:0]  sec_current_limit;
  logic [7:0]  otp [4] = '{8'h01, 8'h03, 8'h50, 8'h00};
  int          error_cnt, checks_done, cyc, i;

  bplm_ctrl #(.MEAS_CYCLES(MC)) dut_u (
    .clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err), .pri_sense_ma(pri_sense_ma),
    .sec_sense_ma(sec_sense_ma), .pri_limit_hit(1'b0),
    .sec_limit_hit(sec_limit_hit), .irq(irq), .pri_pwm(pri_pwm),
    .sec_pwm(sec_pwm), .pri_enable(pri_enable), .sec_enable(sec_enable),
    .two_phase_active(two_phase_active), .sec_phase_180(sec_phase_180),
    .spread_on(spread_on), .pri_vout(pri_vout), .sec_vout(sec_vout),
    .sec_current_limit(sec_current_limit),
    .sec_discharge_enable(sec_discharge_enable));

  bplm_load_model load_u (
    .clk(clk), .rst(rst), .pri_demand_ma(pri_dem), .sec_demand_ma(sec_dem),
    .sec_fault(sec_fault), .pri_sense_ma(pri_sense_ma),
    .sec_sense_ma(sec_sense_ma), .sec_limit_hit(sec_limit_hit));

  // clock and cycle counter
  initial clk = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task conclude;
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // requests held until waitrequest is sampled low
  task bus_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, v};
    avs_write     <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task bus_rd(input logic [7:0] a);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    e = avs_response_err;
    avs_read <= 1'b0;
  endtask

  task settle;
    repeat (4) @(posedge clk);
  endtask

  // launch, watch forced pwm, wait for done, read the result
  task meas(input logic sel, input logic [8:0] code, input logic pwm_end);
    int t0;
    int n;
    bus_wr(`BPLM_ADDR_SEL, {7'h00, sel});
    t0 = cyc;
    repeat (2) @(posedge clk);
    chk(sel ? sec_pwm : pri_pwm, 32'h1);
    n = 0;
    d = 32'h0;
    while (d[0] !== 1'b1 && n < 40) begin
      bus_rd(`BPLM_ADDR_EVENT);
      n++;
    end
    chk(d[0] === 1'b1 && cyc - t0 <= MC + 6, 32'h1);
    bus_rd(`BPLM_ADDR_RES_LO);
    chk(d, {24'h000000, code[7:0]});
    bus_rd(`BPLM_ADDR_RES_HI);
    chk(d, {31'h0, code[8]});
    chk(sel ? sec_pwm : pri_pwm, {31'h0, pwm_end});
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude;
  end

  initial begin
    rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00;
    avs_writedata = 32'h0; avs_byteenable = 4'hF; sec_fault = 1'b0;
    pri_dem = 12'h000; sec_dem = 12'h000;
    error_cnt = 0; checks_done = 0; cyc = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      bus_rd(8'(i * 4));
      chk(d, {24'h000000, otp[i % 4]});
    end
    chk(pri_enable, 32'h1);
    bus_rd(8'h40);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
    // auto pwm threshold edge
    pri_dem <= 12'd599;
    settle;
    chk(pri_pwm, 32'h0);
    pri_dem <= 12'd600;
    settle;
    chk(pri_pwm, 32'h1);
    // single-phase measurements at light load
    pri_dem <= 12'd300;
    sec_dem <= 12'd460;
    bus_wr(`BPLM_ADDR_MASK, 8'h00);
    settle;
    meas(1'b0, 9'(300 / `BPLM_STEP_MA), 1'b0);
    chk(irq, 32'h1);
    bus_wr(`BPLM_ADDR_MASK, 8'h01);
    settle;
    chk(irq, 32'h0);
    bus_rd(`BPLM_ADDR_EVENT);
    chk({31'h0, d[0]}, 32'h1);
    bus_wr(`BPLM_ADDR_EVENT, 8'h01);
    bus_rd(`BPLM_ADDR_EVENT);
    chk({31'h0, d[0]}, 32'h0);
    bus_rd(`BPLM_ADDR_RES_LO);
    chk(d, 32'h0000000F);
    bus_wr(`BPLM_ADDR_MASK, 8'h00);
    meas(1'b1, 9'(460 / `BPLM_STEP_MA), 1'b0);
    chk(irq, 32'h1);
    bus_wr(`BPLM_ADDR_EVENT, 8'h01);
    // forced two-phase at light load
    pri_dem <= 12'd100;
    sec_dem <= 12'd100;
    bus_wr(`BPLM_ADDR_PRI_CTRL1, 8'h05);
    bus_wr(`BPLM_ADDR_PRI_VOUT, 8'h3C);
    settle;
    chk(two_phase_active, 32'h1);
    chk(pri_pwm, 32'h1);
    chk(pri_vout, 32'h3C);
    bus_rd(`BPLM_ADDR_STATUS);
    chk({31'h0, d[1]}, 32'h1);
    bus_wr(`BPLM_ADDR_SEC_CTRL2, 8'h05);
    bus_wr(`BPLM_ADDR_SEC_CTRL1, 8'h08);
    bus_wr(`BPLM_ADDR_SEC_VOUT, 8'h22);
    settle;
    chk(sec_current_limit, 32'h5);
    chk(sec_discharge_enable, 32'h1);
    chk(sec_vout, 32'h3C);
    chk(sec_enable, 32'h1);
    chk(sec_pwm, 32'h1);
    sec_fault <= 1'b1;
    settle;
    sec_fault <= 1'b0;
    bus_rd(`BPLM_ADDR_EVENT);
    chk({31'h0, d[1]}, 32'h1);
    // heavy load: interleaved phases, summed result with msb set
    pri_dem <= 12'd3000;
    sec_dem <= 12'd3000;
    settle;
    chk(sec_phase_180, 32'h1);
    meas(1'b0, 9'(6000 / `BPLM_STEP_MA), 1'b1);
    // spread spectrum only on the internal oscillator
    bus_wr(`BPLM_ADDR_PLL, 8'h00);
    bus_wr(`BPLM_ADDR_CONFIG, 8'h01);
    settle;
    chk(spread_on, 32'h1);
    bus_wr(`BPLM_ADDR_PLL, 8'h01);
    settle;
    chk(spread_on, 32'h0);
    // automatic phase add and shed once two-phase is not forced
    bus_wr(`BPLM_ADDR_PRI_CTRL1, 8'h01);
    pri_dem <= 12'd100;
    settle;
    bus_rd(`BPLM_ADDR_STATUS);
    chk({31'h0, d[2]}, 32'h0);
    pri_dem <= 12'(`BPLM_ADD_PHASE_MA);
    settle;
    bus_rd(`BPLM_ADDR_STATUS);
    chk({31'h0, d[2]}, 32'h1);
    conclude;
  end
endmodule
